// ==== rtl/sst_pkg.sv ====
// Constants for the sequencer stack tail register bank (entries 29 to 31)
// What this block does
// - Bit 15 of each stack word is the access-direction flag, 0 for read and 1 for write, reset 0.
// - Bits 14 to 9 hold the six-bit address of the register that the word targets.
// - Entry 30 sits at index 0x3E and resets to 0x7C00, address field 111110b, all else zero.
// - Entry 31 sits at index 0x3F and resets to 0x7E00, address field 111111b, all else zero.
// - Bit 8 makes the sequencer return to the first entry after the conversion, else it advances.
// - Bits 7 to 4 pick the channel that converter B samples in this step, reset zero.
// - Bits 3 to 0 pick the channel that converter A samples in this step, reset zero.
// - Entry 29 resets with address field 111101b and every other field zero.
package sst_pkg;

   // ****************************************
   // Register indexes (byte address is four times the index)
   // ****************************************
   localparam logic [5:0] IDX_ENTRY_29 = 6'h3D;
   localparam logic [5:0] IDX_ENTRY_30 = 6'h3E;
   localparam logic [5:0] IDX_ENTRY_31 = 6'h3F;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [15:0] RST_ENTRY_29 = 16'h7A00;
   localparam logic [15:0] RST_ENTRY_30 = 16'h7C00;
   localparam logic [15:0] RST_ENTRY_31 = 16'h7E00;
   localparam int NUM_ENTRIES = 3;
   localparam logic [15:0] ENTRY_RESET [NUM_ENTRIES] = '{RST_ENTRY_29, RST_ENTRY_30, RST_ENTRY_31};

   // ****************************************
   // Field positions
   // ****************************************
   localparam int ACCESS_DIR_BIT = 15;
   localparam int TARGET_IDX_MSB = 14;
   localparam int TARGET_IDX_LSB = 9;
   localparam int RETURN_BIT = 8;
   localparam int CONV_B_MSB = 7;
   localparam int CONV_B_LSB = 4;
   localparam int CONV_A_MSB = 3;
   localparam int CONV_A_LSB = 0;

   // ****************************************
   // Stack steps and bus codes
   // ****************************************
   localparam logic [4:0] FIRST_STEP = 5'h00;
   localparam logic [4:0] STEP_29 = 5'h1D;
   localparam logic [4:0] STEP_30 = 5'h1E;
   localparam logic [4:0] LAST_STEP = 5'h1F;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : sst_pkg

// ==== rtl/sst_stack_entry.sv ====
// One sixteen-bit stack entry register with its own reset value
`timescale 1ns/1ps
module sst_stack_entry #(
   parameter logic [15:0] RESET_VAL = 16'h0000
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic wrEn,
   input wire logic [15:0] wrData,
   output logic [15:0] entryWord
);

   logic [15:0] wordQ;
   logic [15:0] wordD;

   // Next value: whole word replaced on a write
   always_comb begin
      wordD = wordQ;
      if (wrEn) begin
         wordD = wrData;
      end
   end

   // Storage
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wordQ <= RESET_VAL;
      end else begin
         wordQ <= wordD;
      end
   end

   assign entryWord = wordQ;

endmodule : sst_stack_entry

// ==== rtl/sst_regs.sv ====
// AHB-Lite register bank for stack entries 29 to 31 and their step logic
`timescale 1ns/1ps
module sst_regs (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic convDone,
   input wire logic [4:0] stepIn,
   output logic tailHit,
   output logic [3:0] chanPickA,
   output logic [3:0] chanPickB,
   output logic nextValid,
   output logic [4:0] nextStep
);

   // ****************************************
   // Bus slave
   // ****************************************
   logic addrPhase;
   logic [2:0] selHit;
   logic [2:0] wrSelQ;
   logic [2:0] wrSelD;
   logic [31:0] hrdataQ;
   logic [31:0] hrdataD;
   logic [15:0] entryWord [sst_pkg::NUM_ENTRIES];
   logic [15:0] rdVal;

   assign addrPhase = hsel && hready && htrans[1];

   // Address decode to a one-hot entry select
   always_comb begin
      if (haddr[31:8] != 24'h000000) begin
         selHit = 3'h0;
      end else if (haddr[7:2] == sst_pkg::IDX_ENTRY_29) begin
         selHit = 3'h1;
      end else if (haddr[7:2] == sst_pkg::IDX_ENTRY_30) begin
         selHit = 3'h2;
      end else if (haddr[7:2] == sst_pkg::IDX_ENTRY_31) begin
         selHit = 3'h4;
      end else begin
         selHit = 3'h0;
      end
   end

   // Read value, forwarding a write that is in its data phase now
   always_comb begin
      rdVal = 16'h0000;
      for (int i = 0; i < sst_pkg::NUM_ENTRIES; i++) begin
         if (selHit[i]) begin
            rdVal = wrSelQ[i] ? hwdata[15:0] : entryWord[i];
         end
      end
   end

   // Next bus state: write select for the data phase, read data captured
   always_comb begin
      wrSelD = 3'h0;
      hrdataD = hrdataQ;
      if (addrPhase && hwrite) begin
         wrSelD = selHit;
      end else if (addrPhase) begin
         hrdataD = {16'h0000, rdVal}; // Upper half and unmapped read as zero
      end
   end

   // Bus registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrSelQ <= 3'h0;
         hrdataQ <= 32'h00000000;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         wrSelQ <= wrSelD;
         hrdataQ <= hrdataD;
         hreadyout <= 1'b1; // Zero wait states
         hresp <= 1'b0; // Always OKAY
      end
   end

   assign hrdata = hrdataQ;

   // ****************************************
   // Stack entries
   // ****************************************
   // entries hold all fields
   for (genvar g = 0; g < sst_pkg::NUM_ENTRIES; g++) begin : gEntry
      sst_stack_entry #(
         .RESET_VAL(sst_pkg::ENTRY_RESET[g])
      ) uEntry (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .wrEn(wrSelQ[g]),
         .wrData(hwdata[15:0]),
         .entryWord(entryWord[g])
      );
   end

   // ****************************************
   // Step logic
   // ****************************************
   logic hitNow;
   logic [15:0] curWord;
   logic tailHitD;
   logic [3:0] chanPickAD;
   logic [3:0] chanPickBD;
   logic nextValidD;
   logic [4:0] nextStepD;

   // Current word when the running step is one of ours
   always_comb begin
      hitNow = 1'b1;
      if (stepIn == sst_pkg::STEP_29) begin
         curWord = entryWord[0];
      end else if (stepIn == sst_pkg::STEP_30) begin
         curWord = entryWord[1];
      end else if (stepIn == sst_pkg::LAST_STEP) begin
         curWord = entryWord[2];
      end else begin
         curWord = 16'h0000;
         hitNow = 1'b0;
      end
   end

   // Next step values
   always_comb begin
      tailHitD = hitNow;
      chanPickAD = curWord[sst_pkg::CONV_A_MSB:sst_pkg::CONV_A_LSB];
      chanPickBD = curWord[sst_pkg::CONV_B_MSB:sst_pkg::CONV_B_LSB];
      nextValidD = convDone && hitNow;
      nextStepD = nextStep;
      if (convDone && hitNow) begin
         if (curWord[sst_pkg::RETURN_BIT]) begin
            nextStepD = sst_pkg::FIRST_STEP;
         end else if (stepIn == sst_pkg::LAST_STEP) begin
            nextStepD = sst_pkg::FIRST_STEP;
         end else begin
            nextStepD = stepIn + 5'h01;
         end
      end
   end

   // Step registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tailHit <= 1'b0;
         chanPickA <= 4'h0;
         chanPickB <= 4'h0;
         nextValid <= 1'b0;
         nextStep <= 5'h00;
      end else begin
         tailHit <= tailHitD;
         chanPickA <= chanPickAD;
         chanPickB <= chanPickBD;
         nextValid <= nextValidD;
         nextStep <= nextStepD;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   logic wr30;
   assign wr30 = addrPhase && hwrite && selHit[1];

   a_dir_flag_store: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr30 ##1 1'b1 |=> entryWord[1][sst_pkg::ACCESS_DIR_BIT] ==
         $past(hwdata[sst_pkg::ACCESS_DIR_BIT], 1))
      else $error("direction flag not stored");

   a_target_idx_store: assert property (@(posedge core_clk) disable iff (!rst_n)
      wr30 ##1 1'b1 |=> entryWord[1][sst_pkg::TARGET_IDX_MSB:sst_pkg::TARGET_IDX_LSB] ==
         $past(hwdata[sst_pkg::TARGET_IDX_MSB:sst_pkg::TARGET_IDX_LSB], 1))
      else $error("address field not stored");

   a_entry30_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
      !$past(rst_n) |-> entryWord[1] == sst_pkg::RST_ENTRY_30)
      else $error("entry 30 reset value wrong");

   a_entry31_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
      !$past(rst_n) |-> entryWord[2] == sst_pkg::RST_ENTRY_31)
      else $error("entry 31 reset value wrong");

   a_entry29_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
      !$past(rst_n) |-> entryWord[0] == sst_pkg::RST_ENTRY_29)
      else $error("entry 29 reset value wrong");

   // return bit sends step to first entry
   a_return_first: assert property (@(posedge core_clk) disable iff (!rst_n)
      convDone && stepIn == sst_pkg::STEP_30 && entryWord[1][sst_pkg::RETURN_BIT] |=>
         nextValid && nextStep == sst_pkg::FIRST_STEP)
      else $error("return to first entry missed");

   a_advance_next: assert property (@(posedge core_clk) disable iff (!rst_n)
      convDone && stepIn == sst_pkg::STEP_29 && !entryWord[0][sst_pkg::RETURN_BIT] |=>
         nextValid && nextStep == sst_pkg::STEP_30)
      else $error("advance to next entry missed");

   a_last_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
      convDone && stepIn == sst_pkg::LAST_STEP && !entryWord[2][sst_pkg::RETURN_BIT] |=>
         nextStep == sst_pkg::FIRST_STEP)
      else $error("no wrap after last entry");

   a_pick_b: assert property (@(posedge core_clk) disable iff (!rst_n)
      stepIn == sst_pkg::STEP_30 |=> tailHit &&
         chanPickB == $past(entryWord[1][sst_pkg::CONV_B_MSB:sst_pkg::CONV_B_LSB]))
      else $error("converter B pick wrong");

   a_pick_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      stepIn == sst_pkg::LAST_STEP |=> tailHit &&
         chanPickA == $past(entryWord[2][sst_pkg::CONV_A_MSB:sst_pkg::CONV_A_LSB]))
      else $error("converter A pick wrong");

endmodule : sst_regs

// ==== tb/sst_host_model.sv ====
// Host bus master model that programs the stack entries over AHB-Lite
`timescale 1ns/1ps
module sst_host_model (
   input wire logic core_clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   // Idle bus at time zero
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // One single word transfer; waits on hready for both phases
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= sst_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge core_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      haddr <= ~a; // Released address does not keep its value
      // word carries direction flag and index
      hwdata <= d;
      do @(posedge core_clk); while (hready !== 1'b1);
      r = hrdata;
      hwdata <= ~d;
   endtask : xfer
endmodule : sst_host_model

// ==== tb/sst_regs_tb_top.sv ====
// Self-checking bench for the stack tail register bank
`timescale 1ns/1ps
module sst_regs_tb_top;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, convDone, tailHit, nextValid;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [4:0] stepIn, nextStep;
   logic [3:0] chanPickA, chanPickB;
   logic [31:0] rd;
   int err_count = 0;
   int check_count = 0;
   int cycles = 0;

   always #20 core_clk = ~core_clk;

   sst_host_model host (.core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata));

   sst_regs dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .convDone(convDone), .stepIn(stepIn), .tailHit(tailHit), .chanPickA(chanPickA),
      .chanPickB(chanPickB), .nextValid(nextValid), .nextStep(nextStep));

   // Compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   // Read one word and compare it
   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h0, rd);
      chk(rd, exp, "read data");
      chk({31'h0, hresp}, 32'h0, "response");
      chk({31'h0, hreadyout}, 32'h1, "ready");
   endtask : rdchk

   // One conversion done at a step, then the answer one edge later
   task automatic step(input logic [4:0] s, input logic v, input logic [4:0] nx,
                       input logic [3:0] a, input logic [3:0] b);
      @(posedge core_clk);
      stepIn <= s;
      convDone <= 1'b1;
      @(posedge core_clk);
      convDone <= 1'b0;
      #1;
      chk({31'h0, nextValid}, {31'h0, v}, "next valid");
      chk({31'h0, tailHit}, {31'h0, v}, "tail hit");
      chk({27'h0, nextStep}, {27'h0, nx}, "next step");
      chk({24'h0, chanPickB, chanPickA}, {24'h0, b, a}, "channel picks");
   endtask : step

   // Reset values and an unmapped place
   task automatic t_reset;
      rdchk(32'hF4, 32'h7A00);
      rdchk(32'hF8, 32'h7C00);
      rdchk(32'hFC, 32'h7E00);
      rdchk(32'h100, 32'h0);
      $display("test reset done");
   endtask : t_reset

   // Every field writable, upper data ignored
   task automatic t_rw;
      host.xfer(1'b1, 32'hF8, 32'hABCDFFFF, rd);
      rdchk(32'hF8, 32'hFFFF);
      host.xfer(1'b1, 32'hFC, 32'h00000000, rd);
      rdchk(32'hFC, 32'h0);
      $display("test rw done");
   endtask : t_rw

   // Return bit, channel picks and wrap of the last entry
   task automatic t_step;
      host.xfer(1'b1, 32'hF4, 32'h7A9C, rd);
      host.xfer(1'b1, 32'hF8, 32'h7D53, rd);
      host.xfer(1'b1, 32'hFC, 32'h7EA6, rd);
      step(5'h1E, 1'b1, 5'h00, 4'h3, 4'h5);
      step(5'h1F, 1'b1, 5'h00, 4'h6, 4'hA);
      step(5'h1D, 1'b1, 5'h1E, 4'hC, 4'h9);
      step(5'h05, 1'b0, 5'h1E, 4'h0, 4'h0);
      $display("test step done");
   endtask : t_step

   // Reset in mid-run brings every entry and the step output back
   task automatic t_rerst;
      host.xfer(1'b1, 32'hFC, 32'h00000123, rd);
      rdchk(32'hFC, 32'h0123);
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      chk({27'h0, nextStep}, 32'h0, "step after reset");
      rdchk(32'hF4, 32'h7A00);
      rdchk(32'hF8, 32'h7C00);
      rdchk(32'hFC, 32'h7E00);
      $display("test reset again done");
   endtask : t_rerst

   // Verdict and end of run
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test

   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         err_count++;
         end_of_test();
      end
   end

   initial begin
      stepIn = 5'h0;
      convDone = 1'b0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_rw();
      t_step();
      t_rerst();
      end_of_test();
   end
endmodule : sst_regs_tb_top
